// file: src/ddrrd_pkg.sv
// Shared constants, types and helpers of the DDR multi-IO read interface
package ddrrd_pkg;

    // ==========================================================
    // Widths and counts
    localparam int          ADDR_BITS      = 32;
    localparam int          MODE_BITS      = 8;
    localparam int          AM_BITS        = ADDR_BITS + MODE_BITS;
    localparam int          BYTE_BITS      = 8;
    localparam int          IO_W           = 4;
    localparam logic [5:0]  AM_BITS_C      = 6'h28;
    localparam logic [3:0]  LP_WINDOW      = 4'h4;
    localparam logic [2:0]  PULSE_ALIGNED  = 3'h0;
    localparam logic [3:0]  LAT_CODE_0     = 4'h4;
    localparam logic [3:0]  LAT_CODE_1     = 4'h5;
    localparam logic [3:0]  LAT_CODE_2     = 4'h6;
    localparam logic [3:0]  LAT_CODE_3     = 4'h8;

    // ==========================================================
    // Synchroniser vector layout
    localparam int          SYNC_W         = 8;
    localparam int          SYN_IO_LSB     = 0;
    localparam int          SYN_SCK        = 4;
    localparam int          SYN_CS_N       = 5;
    localparam int          SYN_PAUSE_N    = 6;
    localparam int          SYN_WP_N       = 7;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        DDR_SINGLE_READ_CMD,
        DDR_DUAL_IO_READ_CMD,
        DDR_QUAD_IO_READ_CMD,
        QUAD_PAGE_PROGRAM_CMD,
        QUAD_OUTPUT_READ_CMD,
        QUAD_IO_READ_CMD,
        PROGRAM_CMD,
        ERASE_CMD,
        REGISTER_WRITE_CMD,
        OTHER_CMD
    } ddrrd_cmd_kind_t;

    typedef struct packed {
        logic [1:0]           lat_code;
        logic                 quad_en;
        logic                 lp_en;
        logic [BYTE_BITS-1:0] learning_pattern;
    } ddrrd_cfg_t;

    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [MODE_BITS-1:0] mode;
    } ddrrd_rd_req_t;

    // ==========================================================
    // Helpers
    function automatic logic [3:0] lat_cycles(input logic [1:0] code);
        case (code)
            2'h0:    lat_cycles = LAT_CODE_0;
            2'h1:    lat_cycles = LAT_CODE_1;
            2'h2:    lat_cycles = LAT_CODE_2;
            default: lat_cycles = LAT_CODE_3;
        endcase
    endfunction

    function automatic logic [2:0] lanes_of(input ddrrd_cmd_kind_t k);
        case (k)
            DDR_DUAL_IO_READ_CMD: lanes_of = 3'h2;
            DDR_QUAD_IO_READ_CMD: lanes_of = 3'h4;
            default:              lanes_of = 3'h1;
        endcase
    endfunction

    function automatic logic is_quad(input ddrrd_cmd_kind_t k);
        is_quad = (k == DDR_QUAD_IO_READ_CMD) || (k == QUAD_PAGE_PROGRAM_CMD) ||
                  (k == QUAD_OUTPUT_READ_CMD) || (k == QUAD_IO_READ_CMD);
    endfunction

    function automatic logic is_ddr(input ddrrd_cmd_kind_t k);
        is_ddr = (k == DDR_SINGLE_READ_CMD) || (k == DDR_DUAL_IO_READ_CMD) ||
                 (k == DDR_QUAD_IO_READ_CMD);
    endfunction

    function automatic logic is_guarded(input ddrrd_cmd_kind_t k);
        is_guarded = (k == PROGRAM_CMD) || (k == ERASE_CMD) ||
                     (k == REGISTER_WRITE_CMD) || (k == QUAD_PAGE_PROGRAM_CMD);
    endfunction

endpackage

// file: src/ddrrd_read_if.sv
// Device-side DDR read interface state logic with command guards
`timescale 1ns/1ps

module ddrrd_read_if (
    input  wire logic                         ref_clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         sck_i,
    input  wire logic                         cs_n_i,
    input  wire logic [ddrrd_pkg::IO_W-1:0]   io_i,
    output logic      [ddrrd_pkg::IO_W-1:0]   io_o,
    output logic      [ddrrd_pkg::IO_W-1:0]   io_oe_o,
    input  wire logic                         pause_n_i,
    input  wire logic                         wp_n_i,
    input  wire ddrrd_pkg::ddrrd_cfg_t        cfg_i,
    input  wire logic                         cmd_valid_i,
    input  wire ddrrd_pkg::ddrrd_cmd_kind_t   cmd_i,
    input  wire logic                         por_busy_i,
    input  wire logic                         low_supply_i,
    input  wire logic [ddrrd_pkg::BYTE_BITS-1:0] rd_data_i,
    input  wire logic                         rd_valid_i,
    output logic                              rd_ready_o,
    output logic                              rd_start_o,
    output ddrrd_pkg::ddrrd_rd_req_t          rd_req_o,
    output logic                              cmd_accept_o,
    output logic                              cmd_reject_o,
    output logic                              exec_o,
    output ddrrd_pkg::ddrrd_cmd_kind_t        exec_kind_o,
    output logic                              pause_o,
    output logic                              wp_o,
    output logic                              ddr_busy_o
);
    import ddrrd_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LAT, ST_OUT, ST_WAIT_CS} ddrrd_state_t;

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [SYNC_W-1:0] syn1_q;
    logic [SYNC_W-1:0] syn2_q;
    logic [SYNC_W-1:0] syn3_q;
    logic [SYNC_W-1:0] pin_q;
    logic [SYNC_W-1:0] pin_prev_q;
    logic [SYNC_W-1:0] agree;

    assign agree = ~(syn2_q ^ syn3_q);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            syn1_q     <= {SYNC_W{1'b1}};
            syn2_q     <= {SYNC_W{1'b1}};
            syn3_q     <= {SYNC_W{1'b1}};
            pin_q      <= {SYNC_W{1'b1}};
            pin_prev_q <= {SYNC_W{1'b1}};
        end else begin
            syn1_q     <= {wp_n_i, pause_n_i, cs_n_i, sck_i, io_i};
            syn2_q     <= syn1_q;
            syn3_q     <= syn2_q;
            pin_q      <= (syn3_q & agree) | (pin_q & ~agree);
            pin_prev_q <= pin_q;
        end
    end

    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_low;
    logic                  cs_rise;
    logic                  cs_fall;
    logic [IO_W-1:0]       io_in;

    assign sck_rise = pin_q[SYN_SCK] & ~pin_prev_q[SYN_SCK];
    assign sck_fall = ~pin_q[SYN_SCK] & pin_prev_q[SYN_SCK];
    assign cs_low   = ~pin_q[SYN_CS_N];
    assign cs_rise  = pin_q[SYN_CS_N] & ~pin_prev_q[SYN_CS_N];
    assign cs_fall  = ~pin_q[SYN_CS_N] & pin_prev_q[SYN_CS_N];
    assign io_in    = pin_q[SYN_IO_LSB +: IO_W];

    // ==========================================================
    // Command intake
    ddrrd_state_t          state_q;
    logic                  cmd_take;
    logic                  cmd_ok;

    assign cmd_take = cmd_valid_i && (state_q == ST_IDLE) && cs_low &&
                      !por_busy_i && !low_supply_i;
    assign cmd_ok   = cfg_i.quad_en || !is_quad(cmd_i);

    // ==========================================================
    // Interface state, address and latency
    logic [2:0]            lanes_q;
    logic [5:0]            bits_q;
    logic [5:0]            bits_d;
    logic                  started_q;
    logic [AM_BITS-1:0]    am_q;
    logic [AM_BITS-1:0]    am_d;
    logic [3:0]            lat_q;
    logic                  addr_edge;
    logic                  enter_lat;

    assign addr_edge = (state_q == ST_ADDR) && (sck_rise || (sck_fall && started_q));
    assign bits_d    = bits_q + {3'h0, lanes_q};
    assign enter_lat = addr_edge && (bits_d == AM_BITS_C);

    always_comb begin
        case (lanes_q)
            3'h4:    am_d = {am_q[AM_BITS-5:0], io_in};
            3'h2:    am_d = {am_q[AM_BITS-3:0], io_in[1:0]};
            default: am_d = {am_q[AM_BITS-2:0], io_in[0]};
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q   <= ST_IDLE;
            lanes_q   <= 3'h1;
            bits_q    <= 6'h00;
            started_q <= 1'b0;
            am_q      <= '0;
            lat_q     <= 4'h0;
        end else if (cs_rise) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_take) begin
                        lanes_q   <= lanes_of(cmd_i);
                        bits_q    <= 6'h00;
                        started_q <= 1'b0;
                        if (cmd_ok && is_ddr(cmd_i)) begin
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_WAIT_CS;
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_edge) begin
                        am_q      <= am_d;
                        bits_q    <= bits_d;
                        started_q <= 1'b1;
                    end
                    if (enter_lat) begin
                        state_q <= ST_LAT;
                        lat_q   <= lat_cycles(cfg_i.lat_code);
                    end
                end
                ST_LAT: begin
                    if (sck_fall) begin
                        lat_q <= lat_q - 4'h1;
                        if (lat_q == 4'h1) begin
                            state_q <= ST_OUT;
                        end
                    end
                end
                ST_OUT, ST_WAIT_CS: begin
                end
            endcase
        end
    end

    // Array read request at latency start
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rd_start_o <= 1'b0;
            rd_req_o   <= '0;
        end else begin
            rd_start_o <= enter_lat && !cs_rise;
            if (enter_lat) begin
                rd_req_o <= am_d;
            end
        end
    end

    // ==========================================================
    // Two-entry read data buffer
    logic [BYTE_BITS-1:0]  buf_mem [2];
    logic                  buf_wr_q;
    logic                  buf_rd_q;
    logic [1:0]            buf_cnt_q;
    logic [1:0]            buf_cnt_d;
    logic                  push;
    logic                  pop_req;
    logic                  pop;

    assign push = rd_valid_i && rd_ready_o;
    assign pop  = pop_req && (buf_cnt_q != 2'h0);

    always_comb begin
        buf_cnt_d = buf_cnt_q;
        if (push && !pop) begin
            buf_cnt_d = buf_cnt_q + 2'h1;
        end else if (pop && !push) begin
            buf_cnt_d = buf_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || cs_rise) begin
            buf_wr_q   <= 1'b0;
            buf_rd_q   <= 1'b0;
            buf_cnt_q  <= 2'h0;
            rd_ready_o <= 1'b1;
        end else begin
            if (push) begin
                buf_mem[buf_wr_q] <= rd_data_i;
                buf_wr_q          <= ~buf_wr_q;
            end
            if (pop) begin
                buf_rd_q <= ~buf_rd_q;
            end
            buf_cnt_q  <= buf_cnt_d;
            rd_ready_o <= (buf_cnt_d != 2'h2);
        end
    end

    // ==========================================================
    // IO drive: learning pattern and DDR output
    logic                  edge_q;
    logic                  edge_fall_q;
    logic [BYTE_BITS-1:0]  out_sh_q;
    logic [3:0]            out_left_q;
    logic [BYTE_BITS-1:0]  src;
    logic [4:0]            lp_idx;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            edge_q      <= 1'b0;
            edge_fall_q <= 1'b0;
        end else begin
            edge_q      <= sck_rise || sck_fall;
            edge_fall_q <= sck_fall;
        end
    end

    assign pop_req = (state_q == ST_OUT) && edge_q && (out_left_q == 4'h0);
    assign lp_idx  = {lat_q, 1'b0} - (edge_fall_q ? 5'h01 : 5'h02);

    always_comb begin
        src = out_sh_q;
        if (out_left_q == 4'h0) begin
            src = (buf_cnt_q != 2'h0) ? buf_mem[buf_rd_q] : '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            io_o       <= '0;
            io_oe_o    <= '0;
            out_sh_q   <= '0;
            out_left_q <= 4'h0;
        end else if (state_q == ST_LAT) begin
            out_left_q <= 4'h0;
            if (edge_q) begin
                // pattern only in last four cycles
                if (cfg_i.lp_en && (lat_q <= LP_WINDOW) && (lat_q != 4'h0)) begin
                    io_oe_o <= {IO_W{1'b1}};
                    io_o    <= {IO_W{cfg_i.learning_pattern[lp_idx[2:0]]}};
                end else begin
                    io_oe_o <= '0;
                end
            end
        end else if (state_q == ST_OUT) begin
            if (edge_q) begin
                unique case (lanes_q)
                    3'h4: begin
                        io_o       <= src[7:4];
                        io_oe_o    <= 4'hf;
                        out_sh_q   <= {src[3:0], 4'h0};
                        out_left_q <= (out_left_q == 4'h0) ? 4'h4 : out_left_q - 4'h4;
                    end
                    3'h2: begin
                        io_o       <= {2'h0, src[7:6]};
                        io_oe_o    <= 4'h3;
                        out_sh_q   <= {src[5:0], 2'h0};
                        out_left_q <= (out_left_q == 4'h0) ? 4'h6 : out_left_q - 4'h2;
                    end
                    default: begin
                        io_o       <= {2'h0, src[7], 1'b0};
                        io_oe_o    <= 4'h2;
                        out_sh_q   <= {src[6:0], 1'b0};
                        out_left_q <= (out_left_q == 4'h0) ? 4'h7 : out_left_q - 4'h1;
                    end
                endcase
            end
        end else begin
            io_oe_o    <= '0;
            out_left_q <= 4'h0;
        end
    end

    // ==========================================================
    // Clock pulse count guard
    logic [2:0]            pulse_cnt_q;
    logic                  pending_q;
    ddrrd_cmd_kind_t       pend_kind_q;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || cs_fall) begin
            pulse_cnt_q <= 3'h0;
        end else if (sck_rise && cs_low) begin
            pulse_cnt_q <= pulse_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pending_q    <= 1'b0;
            pend_kind_q  <= OTHER_CMD;
            exec_o       <= 1'b0;
            exec_kind_o  <= OTHER_CMD;
            cmd_accept_o <= 1'b0;
            cmd_reject_o <= 1'b0;
        end else begin
            cmd_accept_o <= cmd_take && cmd_ok;
            cmd_reject_o <= cmd_take && !cmd_ok;
            exec_o       <= 1'b0;
            if (cs_rise) begin
                pending_q <= 1'b0;
                if (pending_q && is_guarded(pend_kind_q) &&
                    (pulse_cnt_q == PULSE_ALIGNED)) begin
                    exec_o      <= 1'b1;
                    exec_kind_o <= pend_kind_q;
                end
            end else if (cmd_take && cmd_ok) begin
                pending_q   <= 1'b1;
                pend_kind_q <= cmd_i;
            end
        end
    end

    // ==========================================================
    // Pause and write-protect qualification
    logic                  ddr_active;

    assign ddr_active = (state_q == ST_ADDR) || (state_q == ST_LAT) || (state_q == ST_OUT);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pause_o    <= 1'b0;
            wp_o       <= 1'b0;
            ddr_busy_o <= 1'b0;
        end else begin
            // pins ignored in quad or DDR
            pause_o    <= !pin_q[SYN_PAUSE_N] && !cfg_i.quad_en && !ddr_active;
            wp_o       <= !pin_q[SYN_WP_N] && !cfg_i.quad_en && !ddr_active;
            ddr_busy_o <= ddr_active;
        end
    end

endmodule

// file: verification/ddrrd_host_model.sv
// Host model: drives clock, select and IO, samples IO
`timescale 1ns/1ps
module ddrrd_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [3:0] io_i,
    input  wire logic [3:0] dev_oe_i,
    output logic            sck_o,
    output logic            cs_n_o,
    output logic [3:0]      io_o,
    output logic            io_oe_o
);
    logic [7:0] smp[$];
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
        io_oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // One half period of 40 ns; the sample shows the previous edge's output
    task automatic half(input logic en);
        tick(1);
        sck_o <= ~sck_o;
        tick(2);
        @(negedge ref_clk_i);
        if (en) smp.push_back({dev_oe_i, io_i});
        @(posedge ref_clk_i);
    endtask
    task automatic sel();
        tick(1);
        cs_n_o <= 1'b0;
        tick(8);
    endtask
    task automatic send(input int lanes, input logic [39:0] am);
        logic [3:0] v;
        logic [3:0] m;
        m = 4'((1 << lanes) - 1);
        for (int i = 40 - lanes; i >= 0; i -= lanes) begin
            v = 4'(am >> i);
            io_oe_o <= 1'b1;
            io_o <= (v & m) | (~{4{v[0]}} & ~m);
            half(1'b0);
        end
        io_oe_o <= 1'b0;
    endtask
    // lines released, pattern changes each edge
    task automatic run(input int n);
        repeat (n) begin
            io_o <= ~io_o;
            half(1'b1);
        end
    endtask
    task automatic desel();
        tick(1);
        cs_n_o <= 1'b1;
        tick(10);
    endtask
endmodule

// file: verification/ddrrd_read_if_monitor.sv
// Port checker of the DDR read interface
`timescale 1ns/1ps
module ddrrd_read_if_monitor (
    input wire logic                       ref_clk_i,
    input wire logic                       nrst_i,
    input wire logic                       cs_n_i,
    input wire ddrrd_pkg::ddrrd_cfg_t      cfg_i,
    input wire logic                       cmd_valid_i,
    input wire ddrrd_pkg::ddrrd_cmd_kind_t cmd_i,
    input wire logic                       por_busy_i,
    input wire logic                       low_supply_i,
    input wire logic [3:0]                 io_oe_o,
    input wire logic                       rd_start_o,
    input wire logic                       cmd_accept_o,
    input wire logic                       cmd_reject_o,
    input wire logic                       exec_o,
    input wire ddrrd_pkg::ddrrd_cmd_kind_t exec_kind_o,
    input wire logic                       pause_o,
    input wire logic                       wp_o,
    input wire logic                       ddr_busy_o
);
    import ddrrd_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_lockout; cmd_valid_i && (por_busy_i || low_supply_i); endsequence
    sequence s_quad_held; cfg_i.quad_en [*3]; endsequence
    sequence s_idle_held; !ddr_busy_o [*4]; endsequence
    property p_lockout; s_lockout |=> !cmd_accept_o && !cmd_reject_o; endproperty
    property p_gate;
        cmd_valid_i && cmd_i == DDR_QUAD_IO_READ_CMD && !cfg_i.quad_en |=> !cmd_accept_o;
    endproperty
    property p_reject; cmd_reject_o |-> $past(cmd_valid_i) && !$past(cfg_i.quad_en); endproperty
    property p_masks; io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    property p_pause; s_quad_held |-> !pause_o && !wp_o; endproperty
    property p_idle_oe; s_idle_held |-> io_oe_o == 4'h0; endproperty
    property p_exec_kind;
        exec_o |-> exec_kind_o inside {PROGRAM_CMD, ERASE_CMD, REGISTER_WRITE_CMD,
                                       QUAD_PAGE_PROGRAM_CMD};
    endproperty
    property p_exec_cs; exec_o |-> $past(cs_n_i, 2) && !ddr_busy_o; endproperty
    property p_start; rd_start_o |-> ddr_busy_o ##1 !rd_start_o; endproperty
    a_lockout: assert property (p_lockout)
        else $error("command taken under lockout");
    a_gate: assert property (p_gate)
        else $error("quad read accepted without quad enable");
    a_reject: assert property (p_reject)
        else $error("reject without cause");
    a_masks: assert property (p_masks)
        else $error("illegal output enable lanes");
    a_pause: assert property (p_pause)
        else $error("pause or protect active in quad mode");
    a_idle_oe: assert property (p_idle_oe)
        else $error("lines driven outside command");
    a_exec_kind: assert property (p_exec_kind)
        else $error("unguarded kind executed");
    a_exec_cs: assert property (p_exec_cs)
        else $error("execute before select rise");
    a_start: assert property (p_start)
        else $error("array start outside read");
endmodule

bind ddrrd_read_if ddrrd_read_if_monitor u_ddrrd_read_if_monitor (.*);

// file: verification/test_ddrrd_read_if.sv
// Self-checking bench of the DDR read interface
`timescale 1ns/1ps
module test_ddrrd_read_if;
    import ddrrd_pkg::*;
    localparam logic [7:0] LPAT = 8'hb4;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sck, cs_n, cmd_valid_i, por_busy_i, low_supply_i, pause_n_i, wp_n_i, rd_valid_i;
    logic rd_ready_o, rd_start_o, cmd_accept_o, cmd_reject_o, exec_o, pause_o, wp_o;
    logic ddr_busy_o, ex_seen, full_seen;
    logic [3:0] h_io, io_w, io_o, io_oe_o;
    logic [7:0] rd_data_i;
    ddrrd_cfg_t cfg_i;
    ddrrd_cmd_kind_t cmd_i, exec_kind_o;
    ddrrd_rd_req_t rd_req_o;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    assign io_w = (io_oe_o & io_o) | (~io_oe_o & h_io);
    always #5 ref_clk_i = ~ref_clk_i;
    ddrrd_read_if u_ddrrd_read_if (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_w),
        .io_o(io_o), .io_oe_o(io_oe_o), .pause_n_i(pause_n_i), .wp_n_i(wp_n_i),
        .cfg_i(cfg_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .por_busy_i(por_busy_i),
        .low_supply_i(low_supply_i), .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i),
        .rd_ready_o(rd_ready_o), .rd_start_o(rd_start_o), .rd_req_o(rd_req_o),
        .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o), .exec_o(exec_o),
        .exec_kind_o(exec_kind_o), .pause_o(pause_o), .wp_o(wp_o), .ddr_busy_o(ddr_busy_o));
    ddrrd_host_model u_ddrrd_host_model (
        .ref_clk_i(ref_clk_i), .io_i(io_w), .dev_oe_i(io_oe_o), .sck_o(sck),
        .cs_n_o(cs_n), .io_o(h_io), .io_oe_o());
    // Array side, watchers and timeout
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (exec_o === 1'b1) ex_seen <= 1'b1;
        if (ddr_busy_o === 1'b1 && rd_ready_o === 1'b0) full_seen <= 1'b1;
        rd_valid_i <= rd_valid_i ? ddr_busy_o : rd_start_o;
        if (rd_start_o === 1'b1) rd_data_i <= 8'h30;
        else if (rd_valid_i && rd_ready_o) rd_data_i <= rd_data_i + 8'h1;
        if (cyc == 20000) begin
            err_count++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_bit(input logic [39:0] got, input logic [39:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic issue(input ddrrd_cmd_kind_t k, output logic acc, output logic rej);
        acc = 1'b0;
        rej = 1'b0;
        cmd_valid_i <= 1'b1;
        cmd_i <= k;
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        repeat (3) begin
            #1;
            acc = acc | (cmd_accept_o === 1'b1);
            rej = rej | (cmd_reject_o === 1'b1);
            @(posedge ref_clk_i);
        end
    endtask
    // Shared read: first driven sample, last lanes, bytes 30 31 32 seen
    task automatic ddr_read(input ddrrd_cmd_kind_t k, input int lanes, input logic [1:0] code,
            input logic lp, input logic [39:0] am, output int first, output logic [3:0] last,
            output logic hit);
        logic acc, rej;
        logic [511:0] bits;
        logic [7:0] s[$];
        cfg_i <= '{lat_code: code, quad_en: 1'b1, lp_en: lp, learning_pattern: LPAT};
        full_seen <= 1'b0;
        u_ddrrd_host_model.smp.delete();
        u_ddrrd_host_model.sel();
        issue(k, acc, rej);
        chk_bit(acc, 1'b1, "read not accepted");
        u_ddrrd_host_model.send(lanes, am);
        u_ddrrd_host_model.run(64);
        chk_bit(rd_req_o, am, "address and mode");
        s = u_ddrrd_host_model.smp;
        first = -1;
        hit = 1'b0;
        bits = '0;
        foreach (s[i]) begin
            if (first < 0 && s[i][7:4] != 4'h0) first = i;
            if (s[i][7:4] == 4'(lanes == 1 ? 2 : (lanes == 2 ? 3 : 15)))
                bits = (lanes == 1) ? {bits, s[i][1]} : (lanes == 2) ? {bits, s[i][1:0]} :
                       {bits, s[i][3:0]};
        end
        for (int j = 0; j < 488; j++) if (bits[j +: 24] == 24'h303132) hit = 1'b1;
        last = s[s.size() - 1][7:4];
        u_ddrrd_host_model.desel();
    endtask
    task automatic t_single();
        int f0, f3;
        logic [3:0] l;
        logic h;
        ddr_read(DDR_SINGLE_READ_CMD, 1, 2'h0, 1'b0, 40'h12_3456_78a5, f0, l, h);
        chk_bit(40'(l), 40'h2, "single lanes");
        chk_bit(h, 1'b1, "single data");
        ddr_read(DDR_SINGLE_READ_CMD, 1, 2'h3, 1'b0, 40'h9a_bcde_f05a, f3, l, h);
        chk_bit(40'(f3 - f0), 40'h8, "latency spread");
        chk_bit(h, 1'b1, "single stream");
        ddr_read(DDR_DUAL_IO_READ_CMD, 2, 2'h2, 1'b0, 40'hc3_5a96_0f21, f0, l, h);
        chk_bit(40'(l), 40'h3, "dual lanes");
        chk_bit(h, 1'b1, "dual data");
        $display("test single and dual done");
    endtask
    task automatic t_quad();
        int f;
        logic [3:0] l;
        logic h;
        logic [7:0] p;
        ddr_read(DDR_QUAD_IO_READ_CMD, 4, 2'h1, 1'b1, 40'h5e_0d1c_2b3a, f, l, h);
        chk_bit(40'(u_ddrrd_host_model.smp[1][7:4]), 40'h0, "turnaround");
        for (int i = 0; i < 8; i++) p[7 - i] = u_ddrrd_host_model.smp[f + i][0];
        chk_bit(40'(p), 40'(LPAT), "learning pattern");
        chk_bit(40'(l), 40'hf, "quad lanes");
        chk_bit(h, 1'b1, "quad data");
        chk_bit(full_seen, 1'b1, "buffer refuses when full");
        $display("test quad done");
    endtask
    task automatic t_gate();
        logic acc, rej;
        cfg_i.quad_en <= 1'b0;
        u_ddrrd_host_model.sel();
        issue(DDR_QUAD_IO_READ_CMD, acc, rej);
        chk_bit(rej, 1'b1, "quad refused");
        chk_bit(acc, 1'b0, "quad not accepted");
        u_ddrrd_host_model.desel();
        pause_n_i <= 1'b0;
        wp_n_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        chk_bit(pause_o & wp_o, 1'b1, "pause active");
        cfg_i.quad_en <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk_bit(pause_o | wp_o, 1'b0, "pause ignored");
        pause_n_i <= 1'b1;
        wp_n_i <= 1'b1;
        $display("test gate done");
    endtask
    task automatic t_guard();
        logic acc, rej;
        u_ddrrd_host_model.sel();
        por_busy_i <= 1'b1;
        issue(PROGRAM_CMD, acc, rej);
        chk_bit(acc | rej, 1'b0, "taken in power-on reset");
        @(posedge ref_clk_i);
        por_busy_i <= 1'b0;
        low_supply_i <= 1'b1;
        issue(PROGRAM_CMD, acc, rej);
        chk_bit(acc | rej, 1'b0, "taken at low supply");
        @(posedge ref_clk_i);
        low_supply_i <= 1'b0;
        issue(PROGRAM_CMD, acc, rej);
        chk_bit(acc, 1'b1, "taken after lockout");
        u_ddrrd_host_model.desel();
        $display("test guard done");
    endtask
    task automatic t_pulse(input int n, input logic exp);
        logic acc, rej;
        ex_seen <= 1'b0;
        u_ddrrd_host_model.sel();
        issue(PROGRAM_CMD, acc, rej);
        repeat (2 * n) u_ddrrd_host_model.half(1'b0);
        u_ddrrd_host_model.desel();
        chk_bit(ex_seen, exp, "pulse count check");
        if (exp) chk_bit(40'(exec_kind_o), 40'(PROGRAM_CMD), "executed kind");
        $display("test pulse %0d done", n);
    endtask
    initial begin
        cfg_i = '0;
        cmd_valid_i = 1'b0;
        cmd_i = OTHER_CMD;
        por_busy_i = 1'b0;
        low_supply_i = 1'b0;
        pause_n_i = 1'b1;
        wp_n_i = 1'b1;
        rd_valid_i = 1'b0;
        rd_data_i = 8'h0;
        ex_seen = 1'b0;
        full_seen = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        chk_bit(40'(io_oe_o), 40'h0, "reset enables");
        chk_bit(40'(exec_kind_o), 40'(OTHER_CMD), "reset kind");
        t_single();
        t_quad();
        t_gate();
        t_guard();
        t_pulse(8, 1'b1);
        t_pulse(7, 1'b0);
        summarize();
    end
endmodule
